// file: rtl/fsf_map.vh
// Constants of the serial flash front end: opcodes, status layout, reset values, timing
// Functional notes
// - Write-protect pin is active low; with protect mode bits it blocks status writes.
// - With four-lane enable set, write-protect is off and the pin is data lane 2.
// - While selected and paused, output lanes float and clock and input are ignored.
// - With four-lane enable set, pause is off and the pin is data lane 3.
// - Single lane: bits taken on rising clock, read data driven on falling clock.
// - Only bus modes 0 and 3; clock idles low or high at select edges.
// - Dual fast reads 3B and BB use lanes 0 and 1 bidirectionally.
// - Quad fast reads 6B and EB use lanes 0 to 3.
// - Quad instructions are not performed while four-lane enable is clear.
// - Pause starts at pause pin fall with clock low, else after next clock fall.
// - Pause ends at pause pin rise with clock low, else after next clock fall.
// - Pause keeps the partial instruction and page data; transfer resumes in place.
// - While supply reset is asserted nothing runs and no instruction is recognised.
// - For a power-up delay, write enable, program, erase and status write are rejected.
// - Latch starts at 0; program, erase, status write need a prior write enable.
// - Finishing program, erase or status write clears the write enable latch.
// - In power-down only the release power-down instruction is obeyed.
// - In-progress bit 0 is 1 while program, erase or status write runs.
// - While in progress, only status reads and erase suspend are obeyed.
// - In-progress bit clears to 0 when the operation finishes.
// - Status write allowed only per protect mode, write enable latch and pin level.
// - Deselected device keeps every output lane at high impedance.
// - After power-up an instruction needs a select fall from high first.
// - Write enable instruction sets the write enable latch to 1.
// - Protect mode 0,1: low pin locks status, high pin unlocks after write enable; the code ignores the pin in mode 0.
`ifndef FSF_MAP_VH
`define FSF_MAP_VH

// Instruction codes
`define FSF_OP_WRSR 8'h01
`define FSF_OP_PP 8'h02
`define FSF_OP_READ 8'h03
`define FSF_OP_WRDI 8'h04
`define FSF_OP_RDSR1 8'h05
`define FSF_OP_WREN 8'h06
`define FSF_OP_FREAD 8'h0B
`define FSF_OP_SE 8'h20
`define FSF_OP_RDSR2 8'h35
`define FSF_OP_DREAD 8'h3B
`define FSF_OP_BE32 8'h52
`define FSF_OP_CE2 8'h60
`define FSF_OP_QREAD 8'h6B
`define FSF_OP_SUSP 8'h75
`define FSF_OP_RPD 8'hAB
`define FSF_OP_PD 8'hB9
`define FSF_OP_DIO 8'hBB
`define FSF_OP_CE 8'hC7
`define FSF_OP_BE64 8'hD8
`define FSF_OP_QIO 8'hEB

// Status layout: first register bits, second register bits
`define FSF_SR1_BUSY 0
`define FSF_SR1_WR_LATCH 1
`define FSF_SR1_PROT_LSB 2
`define FSF_SR1_PM_LO 7
`define FSF_SR2_PM_HI 0
`define FSF_SR2_FOUR_LANE 1
`define FSF_PROT_RST 6'h00
`define FSF_SR2_RST 2'h0

// Timing: power-up write delay, core clock and dummy clock counts
`define FSF_TPUW_US 10
`define FSF_CLK_MHZ 200
`define FSF_DUMMY_FAST 4'h8
`define FSF_DUMMY_QIO 4'h4

`endif

// file: rtl/fsf_pin_sync.v
// Three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
module fsf_pin_sync #(
  parameter W = 6,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Raw pins and filtered levels
  input wire [W-1:0] pin_i,
  output reg [W-1:0] level_o
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  wire [W-1:0] agree;

  // Only bits whose last two stages match may change the level
  assign agree = ~(s2 ^ s3);

  // Stage one feeds stage two only, so metastability never reaches logic
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level_o <= INIT;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= (s3 & agree) | (level_o & ~agree);
    end
  end

endmodule

// file: rtl/fsf_front_end.v
// Serial flash instruction front end: pin sampling, decode, pause, write gating, status
`timescale 1ns/1ps
`include "fsf_map.vh"
module fsf_front_end #(
  parameter PUW_CYCLES = `FSF_TPUW_US * `FSF_CLK_MHZ
) (
  // Clock and supply reset
  input wire clk_i,
  input wire rst_n_i,
  // Serial port pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire lane0_i,
  output wire lane0_o,
  output wire lane0_oe_n_o,
  input wire lane1_i,
  output wire lane1_o,
  output wire lane1_oe_n_o,
  input wire lane2_i,
  output wire lane2_o,
  output wire lane2_oe_n_o,
  input wire lane3_i,
  output wire lane3_o,
  output wire lane3_oe_n_o,
  // Operation requests to the array core
  output reg op_start_o,
  output reg [7:0] op_code_o,
  output reg [23:0] op_addr_o,
  input wire op_done_i,
  // Page data and read data
  output reg wr_valid_o,
  output reg [7:0] wr_byte_o,
  output reg [23:0] rd_addr_o,
  input wire [7:0] rd_data_i,
  // Status view
  output wire [7:0] status1_o,
  output wire [7:0] status2_o,
  output reg paused_o,
  output reg power_down_o
);

  localparam PH_CMD = 3'd0;
  localparam PH_ADDR = 3'd1;
  localparam PH_DUMMY = 3'd2;
  localparam PH_DIN = 3'd3;
  localparam PH_DOUT = 3'd4;
  localparam PH_WAIT = 3'd5;
  localparam PH_IGN = 3'd6;

  reg rst_q1;
  reg rst_q2;
  wire rst_n;
  wire [5:0] pins;
  wire cs_f;
  wire sclk_f;
  wire [3:0] lin;
  reg sclk_q;
  reg cs_q;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;
  wire cs_fall;
  reg armed;
  reg sel;
  reg [2:0] phase;
  reg [7:0] op;
  reg [31:0] sh;
  reg [5:0] cnt;
  reg [1:0] aw;
  reg [5:0] alen;
  reg [3:0] dl;
  reg [1:0] ow;
  reg [23:0] addr;
  reg [1:0] nbytes;
  reg [7:0] sr_buf1;
  reg [7:0] sr_buf2;
  reg [7:0] osh;
  reg [3:0] ocnt;
  reg [3:0] dout;
  reg drive;
  reg [5:0] prot;
  reg write_enable_latch;
  reg busy;
  reg four_lane_enable;
  reg pm_hi;
  reg [23:0] puw_cnt;
  reg puw_done;
  wire wp_n_eff;
  wire act;
  wire [31:0] nsh;
  wire [5:0] ncnt;
  wire op_ok;
  wire wr_ok;
  wire sr_unlocked;
  wire [7:0] obyte;
  wire [7:0] ob;
  wire [5:0] ostep;

  // Shift lane bits into the low end, highest lane as most significant
  function [31:0] fsf_shift;
    input [31:0] s;
    input [3:0] ln;
    input [1:0] w;
    begin
      case (w)
        2'd1: fsf_shift = {s[29:0], ln[1:0]};
        2'd2: fsf_shift = {s[27:0], ln};
        default: fsf_shift = {s[30:0], ln[0]};
      endcase
    end
  endfunction

  // Bits moved per clock for a lane width code
  function [5:0] fsf_step;
    input [1:0] w;
    begin
      case (w)
        2'd1: fsf_step = 6'h02;
        2'd2: fsf_step = 6'h04;
        default: fsf_step = 6'h01;
      endcase
    end
  endfunction

  // Supply reset released through two flops; all state cleared while it is low
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_n = rst_q2;

  // Select starts low so a pin already low at power-up never looks like a fresh select
  fsf_pin_sync #(
    .W(6),
    .INIT(6'h3C)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .pin_i({lane3_i, lane2_i, lane1_i, lane0_i, sclk_i, cs_n_i}),
    .level_o(pins)
  );
  assign cs_f = pins[0];
  assign sclk_f = pins[1];
  assign lin = pins[5:2];

  // Edge detection on the filtered levels
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b0;
      cs_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_f;
      cs_q <= cs_f;
    end
  end
  assign sclk_rise = sclk_f & ~sclk_q;
  assign sclk_fall = ~sclk_f & sclk_q;
  assign cs_rise = cs_f & ~cs_q;
  assign cs_fall = ~cs_f & cs_q;

  // Quad mode turns the protect pin into a lane, so it then reads as released
  assign wp_n_eff = four_lane_enable ? 1'b1 : lin[2];
  assign sr_unlocked = ~pm_hi & ~(prot[5] & ~wp_n_eff);
  assign wr_ok = puw_done & write_enable_latch;

  // Pause follows the pin only while the clock is low; off in quad and deselected
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      paused_o <= 1'b0;
    else if (cs_f | four_lane_enable | ~sel)
      paused_o <= 1'b0;
    else if (!sclk_f)
      paused_o <= ~lin[3];
  end

  // Clock edges count only while selected and not paused; pause freezes all state moved by clock edges
  assign act = sel & ~cs_f & ~paused_o;
  assign nsh = fsf_shift(sh, lin, (phase == PH_ADDR) ? aw : 2'd0);
  assign ncnt = cnt + fsf_step((phase == PH_ADDR) ? aw : 2'd0);

  // Instruction filter for power-down, busy and quad enable
  assign op_ok = power_down_o ? (nsh[7:0] == `FSF_OP_RPD) :
    busy ? (nsh[7:0] == `FSF_OP_RDSR1 || nsh[7:0] == `FSF_OP_RDSR2 ||
    nsh[7:0] == `FSF_OP_SUSP) :
    ((nsh[7:0] != `FSF_OP_QREAD && nsh[7:0] != `FSF_OP_QIO) | four_lane_enable);

  // Next byte to send: live status or array data
  assign obyte = (op == `FSF_OP_RDSR1) ? status1_o :
    (op == `FSF_OP_RDSR2) ? status2_o : rd_data_i;
  assign ob = (ocnt == 4'h0) ? obyte : osh;
  // Output bits per falling clock for the current lane width
  assign ostep = fsf_step(ow);

  // Power-up write delay counter
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      puw_cnt <= 24'h000000;
      puw_done <= 1'b0;
    end
    else if (!puw_done)
    begin
      puw_cnt <= puw_cnt + 24'h000001;
      puw_done <= (puw_cnt == PUW_CYCLES[23:0]);
    end
  end

  // Main sequencer: select tracking, serial phases, execution at select rise
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed <= 1'b0;
      sel <= 1'b0;
      phase <= PH_CMD;
      op <= 8'h00;
      sh <= 32'h00000000;
      cnt <= 6'h00;
      aw <= 2'd0;
      alen <= 6'h18;
      dl <= 4'h0;
      ow <= 2'd0;
      addr <= 24'h000000;
      nbytes <= 2'd0;
      sr_buf1 <= 8'h00;
      sr_buf2 <= 8'h00;
      osh <= 8'h00;
      ocnt <= 4'h0;
      dout <= 4'h0;
      drive <= 1'b0;
      prot <= `FSF_PROT_RST;
      {four_lane_enable, pm_hi} <= `FSF_SR2_RST;
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      power_down_o <= 1'b0;
      op_start_o <= 1'b0;
      op_code_o <= 8'h00;
      op_addr_o <= 24'h000000;
      wr_valid_o <= 1'b0;
      wr_byte_o <= 8'h00;
      rd_addr_o <= 24'h000000;
    end
    else
    begin
      op_start_o <= 1'b0;
      wr_valid_o <= 1'b0;
      if (cs_f)
        armed <= 1'b1;
      // Completion clears busy and the latch; only a suspend start, which busy lets through, can coincide, and it sets neither
      if (op_done_i)
      begin
        busy <= 1'b0;
        write_enable_latch <= 1'b0;
      end
      if (cs_fall & armed)
        sel <= 1'b1;
      if (sel & cs_rise)
      begin
        // Raising select ends the transfer and resets the instruction state
        sel <= 1'b0;
        phase <= PH_CMD;
        cnt <= 6'h00;
        nbytes <= 2'd0;
        ocnt <= 4'h0;
        drive <= 1'b0;
        if (phase == PH_WAIT)
        begin
          case (op)
            `FSF_OP_WREN: if (puw_done) write_enable_latch <= 1'b1;
            `FSF_OP_WRDI: write_enable_latch <= 1'b0;
            `FSF_OP_PD: power_down_o <= 1'b1;
            `FSF_OP_RPD: power_down_o <= 1'b0;
            `FSF_OP_SUSP:
            begin
              op_start_o <= 1'b1;
              op_code_o <= op;
            end
            default:
            begin
              // Erases and chip erase
              if (wr_ok)
              begin
                op_start_o <= 1'b1;
                op_code_o <= op;
                op_addr_o <= addr;
                busy <= 1'b1;
              end
            end
          endcase
        end
        else if (phase == PH_DIN && cnt == 6'h00 && nbytes != 2'd0 && wr_ok)
        begin
          // Program or status write, only whole bytes and after write enable
          if (op == `FSF_OP_PP || sr_unlocked)
          begin
            op_start_o <= 1'b1;
            op_code_o <= op;
            op_addr_o <= addr;
            busy <= 1'b1;
            if (op == `FSF_OP_WRSR)
            begin
              prot <= sr_buf1[7:2];
              if (nbytes == 2'd2)
                {four_lane_enable, pm_hi} <= sr_buf2[1:0];
            end
          end
        end
      end
      else if (act & sclk_rise)
      begin
        // Input bits are taken on the rising clock
        case (phase)
          PH_CMD:
          begin
            sh <= nsh;
            cnt <= ncnt;
            if (cnt == 6'h07)
            begin
              op <= nsh[7:0];
              cnt <= 6'h00;
              aw <= 2'd0;
              alen <= 6'h18;
              if (!op_ok)
                phase <= PH_IGN;
              else
              begin
                case (nsh[7:0])
                  `FSF_OP_READ, `FSF_OP_FREAD, `FSF_OP_DREAD, `FSF_OP_QREAD, `FSF_OP_PP,
                  `FSF_OP_SE, `FSF_OP_BE32, `FSF_OP_BE64: phase <= PH_ADDR;
                  `FSF_OP_DIO:
                  begin
                    phase <= PH_ADDR;
                    aw <= 2'd1;
                    alen <= 6'h20;
                  end
                  `FSF_OP_QIO:
                  begin
                    phase <= PH_ADDR;
                    aw <= 2'd2;
                    alen <= 6'h20;
                  end
                  `FSF_OP_WRSR: phase <= PH_DIN;
                  `FSF_OP_RDSR1, `FSF_OP_RDSR2:
                  begin
                    phase <= PH_DOUT;
                    ow <= 2'd0;
                  end
                  `FSF_OP_WREN, `FSF_OP_WRDI, `FSF_OP_CE, `FSF_OP_CE2, `FSF_OP_PD,
                  `FSF_OP_RPD, `FSF_OP_SUSP: phase <= PH_WAIT;
                  default: phase <= PH_IGN;
                endcase
              end
            end
          end
          PH_ADDR:
          begin
            sh <= nsh;
            cnt <= ncnt;
            if (ncnt == alen)
            begin
              cnt <= 6'h00;
              addr <= (alen == 6'h20) ? nsh[31:8] : nsh[23:0];
              rd_addr_o <= (alen == 6'h20) ? nsh[31:8] : nsh[23:0];
              dl <= (op == `FSF_OP_QIO) ? `FSF_DUMMY_QIO : `FSF_DUMMY_FAST;
              ow <= (op == `FSF_OP_DREAD || op == `FSF_OP_DIO) ? 2'd1 :
                (op == `FSF_OP_QREAD || op == `FSF_OP_QIO) ? 2'd2 : 2'd0;
              case (op)
                `FSF_OP_READ, `FSF_OP_DIO: phase <= PH_DOUT;
                `FSF_OP_FREAD, `FSF_OP_DREAD, `FSF_OP_QREAD, `FSF_OP_QIO: phase <= PH_DUMMY;
                `FSF_OP_PP: phase <= PH_DIN;
                default: phase <= PH_WAIT;
              endcase
            end
          end
          PH_DUMMY:
          begin
            cnt <= ncnt;
            if (ncnt[3:0] == dl)
            begin
              cnt <= 6'h00;
              phase <= PH_DOUT;
            end
          end
          PH_DIN:
          begin
            sh <= nsh;
            cnt <= ncnt;
            if (ncnt == 6'h08)
            begin
              cnt <= 6'h00;
              if (nbytes != 2'd2)
                nbytes <= nbytes + 2'd1;
              if (op == `FSF_OP_PP)
              begin
                wr_valid_o <= 1'b1;
                wr_byte_o <= nsh[7:0];
              end
              else if (nbytes == 2'd0)
                sr_buf1 <= nsh[7:0];
              else
                sr_buf2 <= nsh[7:0];
            end
          end
          // Extra clocks after a complete short instruction cancel it
          PH_WAIT: phase <= PH_IGN;
          default: phase <= phase;
        endcase
      end
      else if (act & sclk_fall & (phase == PH_DOUT))
      begin
        // Output bits change on the falling clock, most significant lane first
        drive <= 1'b1;
        if (ocnt == 4'h0 && op != `FSF_OP_RDSR1 && op != `FSF_OP_RDSR2)
          rd_addr_o <= rd_addr_o + 24'h000001;
        case (ow)
          2'd1:
          begin
            dout[1:0] <= ob[7:6];
            osh <= {ob[5:0], 2'b00};
          end
          2'd2:
          begin
            dout <= ob[7:4];
            osh <= {ob[3:0], 4'h0};
          end
          default:
          begin
            dout[1] <= ob[7];
            osh <= {ob[6:0], 1'b0};
          end
        endcase
        ocnt <= ((ocnt == 4'h0) ? 4'h8 : ocnt) - ostep[3:0];
      end
    end
  end

  // Lanes float when deselected or paused; dual adds lane 0, quad adds lanes 2 and 3
  assign lane0_o = dout[0];
  assign lane1_o = dout[1];
  assign lane2_o = dout[2];
  assign lane3_o = dout[3];
  assign lane1_oe_n_o = ~(drive & act);
  assign lane0_oe_n_o = ~(drive & act & (ow != 2'd0));
  assign lane2_oe_n_o = ~(drive & act & (ow == 2'd2));
  assign lane3_oe_n_o = ~(drive & act & (ow == 2'd2));

  // Status views; in-progress sits at bit 0
  assign status1_o = {prot, write_enable_latch, busy};
  assign status2_o = {6'h00, four_lane_enable, pm_hi};

endmodule

// file: verif/fsf_front_end_sva.sv
// Concurrent checks on the ports of the serial flash front end
`timescale 1ns/1ps
`include "fsf_map.vh"
module fsf_front_end_sva (
  // Clock and supply reset
  input wire clk_i,
  input wire rst_n_i,
  // Link select and lane enables
  input wire cs_n_i,
  input wire lane0_oe_n_o,
  input wire lane1_oe_n_o,
  input wire lane2_oe_n_o,
  input wire lane3_oe_n_o,
  // Core handshake and status
  input wire op_start_o,
  input wire [7:0] op_code_o,
  input wire op_done_i,
  input wire [7:0] status1_o,
  input wire [7:0] status2_o,
  input wire paused_o,
  input wire power_down_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Select filter is four cycles deep, so eight quiet cycles must float every lane
  deselect_float_a: assert property (cs_n_i [*8] |-> lane0_oe_n_o && lane1_oe_n_o
    && lane2_oe_n_o && lane3_oe_n_o) else $error("lane driven while deselected");
  pause_float_a: assert property (paused_o |-> lane1_oe_n_o)
    else $error("output driven during pause");
  pause_quad_off_a: assert property (paused_o |-> !status2_o[`FSF_SR2_FOUR_LANE])
    else $error("pause taken with four-lane enable set");
  quad_lanes_off_a: assert property (!status2_o[`FSF_SR2_FOUR_LANE]
    |-> lane2_oe_n_o && lane3_oe_n_o)
    else $error("upper lanes driven with four-lane enable clear");
  busy_filter_a: assert property (op_start_o && $past(status1_o[0])
    |-> op_code_o == `FSF_OP_SUSP) else $error("operation started while busy");
  start_busy_a: assert property (op_start_o && op_code_o != `FSF_OP_SUSP
    |-> ##[0:2] status1_o[0]) else $error("busy not raised by start");
  done_clear_a: assert property (op_done_i && status1_o[0]
    |=> status1_o[1:0] == 2'b00) else $error("busy or latch kept after done");
  latch_needed_a: assert property (op_start_o && op_code_o != `FSF_OP_SUSP
    |-> $past(status1_o[1])) else $error("write started without latch");
  pd_quiet_a: assert property (power_down_o |-> !op_start_o)
    else $error("operation started in power-down");
  sel_no_pause_a: assert property (cs_n_i [*8] |-> !paused_o)
    else $error("pause while deselected");
  wrsr_lock_a: assert property (op_start_o && op_code_o == `FSF_OP_WRSR
    |-> !$past(status2_o[`FSF_SR2_PM_HI])) else $error("status write while locked");
endmodule

bind fsf_front_end fsf_front_end_sva u_sva (
  .clk_i,
  .rst_n_i,
  .cs_n_i,
  .lane0_oe_n_o,
  .lane1_oe_n_o,
  .lane2_oe_n_o,
  .lane3_oe_n_o,
  .op_start_o,
  .op_code_o,
  .op_done_i,
  .status1_o,
  .status2_o,
  .paused_o,
  .power_down_o
);

// file: verif/fsf_host_model.sv
// SPI host model: select, clock, lane 0 and the protect and pause pins
`timescale 1ns/1ps
module fsf_host_model (
  // Core clock paces the link
  input wire clk_i,
  // Link pins
  output reg cs_n_o,
  output reg sclk_o,
  output reg mosi_o,
  output reg wp_n_o,
  output reg hold_n_o,
  input wire miso_i
);
  reg cpol = 1'b0;

  // Deselected at power-up so the first frame starts with a select fall
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    wp_n_o = 1'b1;
    hold_n_o = 1'b1;
  end

  // Half a link period: 8 core cycles, 80 ns per bit
  task half;
    begin
      repeat (8) @(posedge clk_i);
      #1;
    end
  endtask

  // Select edge with the clock parked at its idle level for mode 0 or 3
  task sel(input v);
    begin
      half;
      sclk_o = cpol;
      half;
      cs_n_o = v;
      half;
    end
  endtask

  // One byte MSB first: data set after falling edge, read data taken at rising
  task xb(input [7:0] t, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        sclk_o = 1'b0;
        mosi_o = t[i];
        half;
        sclk_o = 1'b1;
        r[i] = miso_i;
        half;
      end
      mosi_o = ~mosi_o;
    end
  endtask

  // Pause pin and clock level; select is never raised here
  task pin(input h, input c);
    begin
      hold_n_o = h;
      sclk_o = c;
      half;
      half;
    end
  endtask
endmodule

// file: verif/test_fsf_front_end.sv
// Self-checking bench for the flash front end with a host model on the link
`timescale 1ns/1ps
`include "fsf_map.vh"
module test_fsf_front_end;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg op_done_i = 1'b0;
  reg [7:0] rd_data_i = 8'h00;
  wire cs_n, sclk, mosi, wp_n, hold_n, miso;
  wire [3:0] lo;
  wire [3:0] oen;
  wire op_start, wr_valid, paused, pd;
  wire [7:0] op_code, wr_byte, st1, st2;
  wire [23:0] op_addr, rd_addr;
  integer failures = 0;
  integer num_checks = 0;
  integer starts = 0;
  integer i;
  reg [31:0] seed = 32'h2B5B;
  reg [7:0] last_code, last_wr, r, d;
  reg [31:0] a;
  reg [7:0] codes [0:2];

  // Undriven data line shows the inverse of its last value, never a stale bit
  assign miso = oen[1] ? ~lo[1] : lo[1];

  fsf_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
    .wp_n_o(wp_n), .hold_n_o(hold_n), .miso_i(miso));

  fsf_front_end #(.PUW_CYCLES(400)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .lane0_i(oen[0] ? mosi : lo[0]), .lane0_o(lo[0]), .lane0_oe_n_o(oen[0]),
    .lane1_i(miso), .lane1_o(lo[1]), .lane1_oe_n_o(oen[1]),
    .lane2_i(oen[2] ? wp_n : lo[2]), .lane2_o(lo[2]), .lane2_oe_n_o(oen[2]),
    .lane3_i(oen[3] ? hold_n : lo[3]), .lane3_o(lo[3]), .lane3_oe_n_o(oen[3]),
    .op_start_o(op_start), .op_code_o(op_code), .op_addr_o(op_addr), .op_done_i(op_done_i),
    .wr_valid_o(wr_valid), .wr_byte_o(wr_byte), .rd_addr_o(rd_addr), .rd_data_i(rd_data_i),
    .status1_o(st1), .status2_o(st2), .paused_o(paused), .power_down_o(pd));

  // Core clock, 5 ns period
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Array core stand-in: note every start and page byte
  always @(posedge clk_i)
  begin
    if (op_start === 1'b1)
    begin
      starts = starts + 1;
      last_code = op_code;
    end
    if (wr_valid === 1'b1)
      last_wr = wr_byte;
  end

  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task give_verdict;
    begin
      if (failures == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask

  // Core reports the running operation finished
  task done;
    begin
      op_done_i = 1'b1;
      tick(1);
      op_done_i = 1'b0;
      tick(2);
    end
  endtask

  // Opcode, n random bytes (last kept in d, read back in r), then v if v[8] is set
  task cmd(input [7:0] c, input integer n, input [8:0] v);
    integer k;
    begin
      u_host.sel(1'b0);
      u_host.xb(c, r);
      for (k = 0; k < n; k = k + 1)
      begin
        seed = xs(seed);
        d = seed[7:0];
        a = {a[23:0], d};
        u_host.xb(d, r);
      end
      if (v[8])
        u_host.xb(v[7:0], r);
      u_host.sel(1'b1);
      tick(6);
    end
  endtask

  // Cuts a hung run short
  initial
  begin
    #400000;
    failures = failures + 1;
    give_verdict;
  end

  initial
  begin
    codes[0] = `FSF_OP_DREAD;
    codes[1] = `FSF_OP_QREAD;
    codes[2] = `FSF_OP_QIO;
    tick(3);
    check("lanes_in_reset", oen, 4'hF);
    check("status_in_reset", st1, 8'h00);
    check("status2_in_reset", st2, 8'h00);
    tick(2);
    rst_n_i = 1'b1;
    tick(12);
    cmd(`FSF_OP_WREN, 0, 9'h000);
    check("wel_in_delay", st1[1], 1'b0);
    tick(400);
    cmd(`FSF_OP_WREN, 0, 9'h000);
    check("wel_set", st1[1], 1'b1);
    u_host.cpol = 1'b1;
    cmd(`FSF_OP_RDSR1, 1, 9'h000);
    check("status_mode3", r, 8'h02);
    u_host.cpol = 1'b0;
    cmd(`FSF_OP_PP, 4, 9'h000);
    check("page_byte", last_wr, d);
    check("pp_code", last_code, `FSF_OP_PP);
    check("busy_set", st1[0], 1'b1);
    check("pp_addr", op_addr, a[31:8]);
    cmd(`FSF_OP_RDSR1, 1, 9'h000);
    check("status_busy", r, 8'h03);
    cmd(`FSF_OP_SE, 3, 9'h000);
    check("erase_in_busy", starts, 1);
    done;
    check("busy_wel_clear", st1[1:0], 2'b00);
    cmd(`FSF_OP_PP, 4, 9'h000);
    check("pp_no_latch", starts, 1);
    seed = xs(seed);
    rd_data_i = seed[15:8];
    cmd(`FSF_OP_READ, 4, 9'h000);
    check("read_byte", r, rd_data_i);
    // One byte loaded for the data byte and one more at the closing clock fall
    check("read_addr", rd_addr, a[31:8] + 24'h000002);
    cmd(`FSF_OP_WREN, 0, 9'h000);
    u_host.sel(1'b0);
    u_host.xb(`FSF_OP_RDSR1, r);
    u_host.pin(1'b0, 1'b1);
    check("pause_clk_high", paused, 1'b0);
    u_host.pin(1'b0, 1'b0);
    check("pause_on", paused, 1'b1);
    check("pause_float", oen[1], 1'b1);
    u_host.pin(1'b1, 1'b0);
    check("pause_off", paused, 1'b0);
    u_host.xb(8'h00, r);
    u_host.sel(1'b1);
    check("pause_resume", r, 8'h02);
    u_host.pin(1'b0, 1'b0);
    check("pause_deselected", paused, 1'b0);
    u_host.pin(1'b1, 1'b0);
    cmd(`FSF_OP_PD, 0, 9'h000);
    check("pd_on", pd, 1'b1);
    cmd(`FSF_OP_WRDI, 0, 9'h000);
    check("pd_ignores", st1[1], 1'b1);
    cmd(`FSF_OP_RPD, 0, 9'h000);
    check("pd_off", pd, 1'b0);
    cmd(`FSF_OP_WRSR, 0, 9'h180);
    check("wrsr_code", last_code, `FSF_OP_WRSR);
    done;
    check("status_written", st1, 8'h80);
    check("status2_kept", st2, 8'h00);
    cmd(`FSF_OP_WREN, 0, 9'h000);
    u_host.wp_n_o = 1'b0;
    cmd(`FSF_OP_WRSR, 0, 9'h100);
    check("wp_locks", starts, 2);
    u_host.wp_n_o = 1'b1;
    cmd(`FSF_OP_WRSR, 0, 9'h100);
    check("wp_unlocks", starts, 3);
    done;
    check("status_cleared", st1, 8'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      u_host.sel(1'b0);
      u_host.xb(codes[i], r);
      repeat (6) u_host.xb(8'h00, r);
      check("fast_read_lanes", oen, (i == 0) ? 4'hC : 4'hF);
      u_host.sel(1'b1);
    end
    give_verdict;
  end
endmodule
